// File: rtl/rcdt_timer.v
// Behaviour
// - Stop-on-receive halts timer after four received bits
// - Stop-on-receive clear: reception never halts timer
// - Trimming modes ignore stop-on-receive bit
// - Mode 00 no autostart; 01 starts at transmit end
// - Trimming modes start and stop on rising edges
// - Auto-reload: reload value at zero, keep counting, except start mode 10, which holds at zero
// - No auto-reload: stop halted at zero, except start mode 10, which holds at zero and keeps running
// - Underflow sets the interrupt request flag
// - Clock select 00 fast, 01 slow tick
// - Clock select 10 timer3, 11 timer2 underflow
// - Reload bytes copied into counter at start
// - Reload writes do not disturb a running count
// - Live count readable as high and low bytes
// - Start/stop write changes run flag only where masked
// - Running state reported in start/stop bit 4
`timescale 1ns/1ps
`include "rcdt_map.vh"
module rcdt_timer (
    input wire sys_clk_i, // System clock, 100 MHz
    input wire resetn_i, // Async reset, active low
    input wire [7:0] addr_i, // Register byte address
    input wire [7:0] wdata_i, // Write data
    input wire wr_i, // Write strobe
    input wire rd_i, // Read strobe
    output reg [7:0] rdata_o, // Read data, cycle after the strobe
    input wire tick_fast_i, // Pulse per 13.56 MHz input period
    input wire tick_slow_i, // Pulse per 211.875 kHz input period
    input wire timer3_uf_i, // Underflow pulse of the third timer
    input wire timer2_uf_i, // Underflow pulse of the second timer
    input wire tx_end_i, // Pulse at end of a transmission
    input wire rx_bit_i, // Pulse per received bit
    input wire rx_active_i, // High while a frame is received
    input wire osc_trim_i, // Oscillator trimming level, asynchronous
    output reg underflow_o, // One-cycle pulse on underflow
    output wire running_o, // Timer running flag
    output wire irq_o // Level interrupt
);
    reg [7:0] ctrl_r;
    reg [7:0] reload_hi_r;
    reg [7:0] reload_lo_r;
    reg [15:0] count_r;
    reg [15:0] count_nxt;
    reg run_r;
    reg run_nxt;
    reg [2:0] rx_bits_r;
    reg [1:0] irq_stat_r;
    reg [1:0] irq_stat_nxt;
    reg [1:0] irq_mask_r;
    reg tick;
    reg uf_nxt;
    reg stop_evt;
    reg rx_stop;

    wire trim_edge;
    wire stop_rx = ctrl_r[`RCDT_CTL_STOP_RX];
    wire auto_rl = ctrl_r[`RCDT_CTL_AUTO_RELOAD];
    wire [1:0] start_mode = ctrl_r[`RCDT_CTL_START_HI:`RCDT_CTL_START_LO];
    wire [1:0] clk_sel = ctrl_r[`RCDT_CTL_CLK_HI:`RCDT_CTL_CLK_LO];
    wire trim_mode = start_mode[1];
    wire [15:0] reload_value = {reload_hi_r, reload_lo_r};

    // Address compare, shared by the write and read paths
    function hit;
        input [7:0] a;
        input [7:0] ref_addr;
        begin
            hit = (a == ref_addr);
        end
    endfunction

    // Trimming edges come from another clock, so synchronise first
    rcdt_sync2 u_trim_sync (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .async_i(osc_trim_i),
        .level_o(),
        .rise_o(trim_edge)
    );

    wire ss_wr = wr_i & hit(addr_i, `RCDT_ADDR_START_STOP);
    wire sw_touch = ss_wr & wdata_i[`RCDT_SS_MASK_BIT];
    wire sw_val = wdata_i[`RCDT_SS_RUN_BIT];
    wire stat_rd = rd_i & hit(addr_i, `RCDT_ADDR_IRQ_STATUS);

    // Counting input select
    always @* begin
        case (clk_sel)
            `RCDT_CLK_FAST: tick = tick_fast_i;
            `RCDT_CLK_SLOW: tick = tick_slow_i;
            `RCDT_CLK_TIMER3: tick = timer3_uf_i;
            `RCDT_CLK_TIMER2: tick = timer2_uf_i;
            default: tick = 1'b0;
        endcase
    end

    // Reception stop: fourth bit of the frame, never in trimming modes
    always @* begin
        rx_stop = stop_rx & ~trim_mode & rx_bit_i & rx_active_i
                  & (rx_bits_r == `RCDT_STOP_RX_BITS - 3'd1);
    end

    // Run and count next state; software start/stop has highest priority
    always @* begin
        run_nxt = run_r;
        count_nxt = count_r;
        uf_nxt = 1'b0;
        stop_evt = 1'b0;
        if (sw_touch) begin
            run_nxt = sw_val;
            if (sw_val && !run_r) begin
                count_nxt = reload_value;
            end
            stop_evt = run_r & ~sw_val;
        end else if (!run_r) begin
            if ((start_mode == `RCDT_START_TX_END && tx_end_i) ||
                    (trim_mode && trim_edge)) begin
                run_nxt = 1'b1;
                count_nxt = reload_value;
            end
        end else if (trim_mode && trim_edge) begin
            run_nxt = 1'b0;
            stop_evt = 1'b1;
        end else if (rx_stop) begin
            run_nxt = 1'b0;
            stop_evt = 1'b1;
        end else if (tick) begin
            if (count_r == 16'h0000) begin
                // Trimming without underflow simply holds at zero
                if (start_mode != `RCDT_START_TRIM) begin
                    uf_nxt = 1'b1;
                    if (auto_rl) begin
                        count_nxt = reload_value;
                    end else begin
                        run_nxt = 1'b0;
                        stop_evt = 1'b1;
                    end
                end
            end else begin
                count_nxt = count_r - 16'h0001;
            end
        end
    end

    // Status flags: a hardware set wins over the clearing read
    always @* begin
        irq_stat_nxt = irq_stat_r;
        if (stat_rd) begin
            irq_stat_nxt = 2'b00;
        end
        if (uf_nxt) begin
            irq_stat_nxt[`RCDT_IRQ_UNDERFLOW] = 1'b1;
        end
        if (stop_evt) begin
            irq_stat_nxt[`RCDT_IRQ_STOPPED] = 1'b1;
        end
    end

    // Timer state
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            run_r <= 1'b0;
            count_r <= 16'h0000;
            underflow_o <= 1'b0;
            irq_stat_r <= 2'b00;
            rx_bits_r <= 3'd0;
        end else begin
            run_r <= run_nxt;
            count_r <= count_nxt;
            underflow_o <= uf_nxt;
            irq_stat_r <= irq_stat_nxt;
            // Bits counted per frame; saturates so only the fourth one fires
            if (!rx_active_i) begin
                rx_bits_r <= 3'd0;
            end else if (rx_bit_i && rx_bits_r != `RCDT_STOP_RX_BITS) begin
                rx_bits_r <= rx_bits_r + 3'd1;
            end
        end
    end

    // Software registers; reload writes land only in the holding bytes
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_r <= `RCDT_RST_CONTROL;
            reload_hi_r <= `RCDT_RST_RELOAD;
            reload_lo_r <= `RCDT_RST_RELOAD;
            irq_mask_r <= 2'b00;
        end else if (wr_i) begin
            if (hit(addr_i, `RCDT_ADDR_CONTROL)) begin
                ctrl_r <= wdata_i & `RCDT_CTL_WMASK;
            end
            if (hit(addr_i, `RCDT_ADDR_RELOAD_HI)) begin
                reload_hi_r <= wdata_i;
            end
            if (hit(addr_i, `RCDT_ADDR_RELOAD_LO)) begin
                reload_lo_r <= wdata_i;
            end
            if (hit(addr_i, `RCDT_ADDR_IRQ_MASK)) begin
                irq_mask_r <= wdata_i[1:0];
            end
        end
    end

    // Read path; unmapped addresses return zero
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                `RCDT_ADDR_START_STOP: rdata_o <= {3'b000, run_r, 4'h0};
                `RCDT_ADDR_CONTROL: rdata_o <= ctrl_r;
                `RCDT_ADDR_RELOAD_HI: rdata_o <= reload_hi_r;
                `RCDT_ADDR_RELOAD_LO: rdata_o <= reload_lo_r;
                `RCDT_ADDR_COUNT_HI: rdata_o <= count_r[15:8];
                `RCDT_ADDR_COUNT_LO: rdata_o <= count_r[7:0];
                `RCDT_ADDR_IRQ_STATUS: rdata_o <= {6'h00, irq_stat_r};
                `RCDT_ADDR_IRQ_MASK: rdata_o <= {6'h00, irq_mask_r};
                default: rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

    assign running_o = run_r;
    assign irq_o = |(irq_stat_r & irq_mask_r);
endmodule // rcdt_timer

// File: rtl/rcdt_map.vh
`ifndef RCDT_MAP_VH
`define RCDT_MAP_VH
// Register byte offsets
`define RCDT_ADDR_START_STOP 8'h0e
`define RCDT_ADDR_CONTROL 8'h0f
`define RCDT_ADDR_RELOAD_HI 8'h10
`define RCDT_ADDR_RELOAD_LO 8'h11
`define RCDT_ADDR_COUNT_HI 8'h12
`define RCDT_ADDR_COUNT_LO 8'h13
`define RCDT_ADDR_IRQ_STATUS 8'h40
`define RCDT_ADDR_IRQ_MASK 8'h41
// Control field positions
`define RCDT_CTL_STOP_RX 7
`define RCDT_CTL_START_HI 5
`define RCDT_CTL_START_LO 4
`define RCDT_CTL_AUTO_RELOAD 3
`define RCDT_CTL_CLK_HI 1
`define RCDT_CTL_CLK_LO 0
// Writable control bits; reserved bits read zero
`define RCDT_CTL_WMASK 8'hbb
// Start/stop register positions
`define RCDT_SS_RUN_BIT 4
`define RCDT_SS_MASK_BIT 0
// Start modes
`define RCDT_START_NONE 2'b00
`define RCDT_START_TX_END 2'b01
`define RCDT_START_TRIM 2'b10
`define RCDT_START_TRIM_UF 2'b11
// Clock selections
`define RCDT_CLK_FAST 2'b00
`define RCDT_CLK_SLOW 2'b01
`define RCDT_CLK_TIMER3 2'b10
`define RCDT_CLK_TIMER2 2'b11
// Bits of a frame after which reception stops the timer
`define RCDT_STOP_RX_BITS 3'd4
// Reset values
`define RCDT_RST_CONTROL 8'h00
`define RCDT_RST_RELOAD 8'h00
`define RCDT_RST_MASK 8'h00
// Interrupt status bit positions
`define RCDT_IRQ_UNDERFLOW 0
`define RCDT_IRQ_STOPPED 1
`endif

// File: rtl/rcdt_sync2.v
`timescale 1ns/1ps
// Two-stage synchroniser with a rising edge detect behind the second stage
module rcdt_sync2 (
    input wire sys_clk_i, // System clock
    input wire resetn_i, // Async reset, active low
    input wire async_i, // Level from another domain
    output wire level_o, // Synchronised level
    output wire rise_o // One-cycle pulse on a rising edge
);
    reg meta_r;
    reg sync_r;
    reg prev_r;

    // The first stage feeds only the second, to contain metastability
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            meta_r <= async_i;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign level_o = sync_r;
    assign rise_o = sync_r & ~prev_r;
endmodule // rcdt_sync2

// File: sim/rcdt_timer_properties.sv
`timescale 1ns/1ps
// Control and mask are shadowed from bus writes
module rcdt_chk (
    input wire sys_clk_i, // Clock
    input wire resetn_i, // Reset
    input wire [7:0] addr_i, // Address
    input wire [7:0] wdata_i, // Data in
    input wire wr_i, // Write
    input wire rd_i, // Read
    input wire [7:0] rdata_o, // Data out
    input wire tick_fast_i, // Tick
    input wire tick_slow_i, // Tick
    input wire timer3_uf_i, // Cascade
    input wire timer2_uf_i, // Cascade
    input wire tx_end_i, // Tx end
    input wire rx_bit_i, // Rx bit
    input wire rx_active_i, // Frame
    input wire osc_trim_i, // Trim
    input wire underflow_o, // Underflow
    input wire running_o, // Run
    input wire irq_o // Irq
);
    reg [7:0] ctl_r;
    reg msk_r;
    reg [2:0] rxc_r;
    wire ss = wr_i && addr_i == 8'h0e;
    // Bit count saturates so a long frame never matches the fourth bit again
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctl_r <= 8'h00;
            msk_r <= 1'b0;
            rxc_r <= 3'd0;
        end else begin
            if (wr_i && addr_i == 8'h0f) ctl_r <= wdata_i;
            if (wr_i && addr_i == 8'h41) msk_r <= wdata_i[0];
            rxc_r <= rx_active_i ? rxc_r + {2'd0, rx_bit_i && rxc_r != 3'd4} : 3'd0;
        end
    end
    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (!resetn_i);
    AST_RD_IDLE: assert property (!$past(rd_i) |-> rdata_o == 8'h00) else $error("rd");
    AST_SS_GO: assert property (ss && wdata_i[4] && wdata_i[0] |=> running_o) else $error("go");
    AST_SS_HALT: assert property (ss && wdata_i == 8'h01 |=> !running_o) else $error("halt");
    AST_NO_AUTO: assert property (!running_o && ctl_r[5:4] == 2'b00 && !(ss && wdata_i[0])
        |=> !running_o) else $error("auto");
    AST_TX_GO: assert property (tx_end_i && ctl_r[5:4] == 2'b01 && !running_o && !ss
        |=> running_o) else $error("tx");
    AST_RX_STOP: assert property (rx_bit_i && rxc_r == 3'd3 && ctl_r[7] && !ctl_r[5] && !ss
        && !tx_end_i |=> !running_o) else $error("rx");
    AST_UF_STOP: assert property (underflow_o && !ctl_r[3] && !$past(wr_i)
        |-> !running_o) else $error("stop");
    AST_UF_RELOAD: assert property (underflow_o && ctl_r[3] && !ctl_r[5] && !$past(wr_i)
        && !$past(rx_bit_i) |-> running_o) else $error("reload");
    AST_UF_IRQ: assert property (underflow_o && msk_r |-> ##[0:1] irq_o) else $error("irq");
    COV_UF: cover property (underflow_o && ctl_r[3]);
    COV_RX: cover property (rx_bit_i && rxc_r == 3'd3 && running_o);
    COV_TX: cover property (tx_end_i && !running_o);
endmodule // rcdt_chk
bind rcdt_timer rcdt_chk i_rcdt_chk (.*);

// File: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic sys_clk_i = 0, resetn_i = 0, wr_i = 0, rd_i = 0, rdq = 0;
    logic [7:0] addr_i = 0, wdata_i = 0, rdata_o, ufn = 0;
    logic tick_fast_i = 0, tick_slow_i = 0, timer3_uf_i = 0, timer2_uf_i = 0;
    logic tx_end_i = 0, rx_bit_i = 0, rx_active_i = 0, osc_trim_i = 0;
    logic underflow_o, running_o, irq_o;
    logic [7:0] expq[$];
    logic [15:0] rv;
    int err_total = 0, cmp_count = 0;
    rcdt_timer i_rcdt_timer (.*);
    initial forever #5 sys_clk_i = ~sys_clk_i;
    task chk(input logic [7:0] s, input logic [7:0] e);
        cmp_count++;
        if (s !== e) begin
            err_total++;
            $display("wrong value at %0t: %h, expected %h", $time, s, e);
        end
    endtask
    // Read data stand only in the cycle after the strobe; underflow pulses are counted
    always @(posedge sys_clk_i) begin
        if (rdq) chk(rdata_o, expq.pop_front());
        if (underflow_o === 1'b1) ufn <= ufn + 8'h01;
        rdq <= rd_i;
    end
    // One strobe plus an idle edge, so no strobe is assigned twice in a time step
    task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        if (!w) expq.push_back(d);
        addr_i <= a;
        wdata_i <= d;
        {wr_i, rd_i} <= {w, !w};
        @(posedge sys_clk_i);
        {wr_i, rd_i} <= 2'b00;
        @(posedge sys_clk_i);
    endtask
    task pl(input logic [5:0] v);
        {rx_bit_i, tx_end_i, timer2_uf_i, timer3_uf_i, tick_slow_i, tick_fast_i} <= v;
        @(posedge sys_clk_i);
        {rx_bit_i, tx_end_i, timer2_uf_i, timer3_uf_i, tick_slow_i, tick_fast_i} <= 6'h00;
        @(posedge sys_clk_i);
    endtask
    task rn(input logic e);
        chk({7'h00, running_o}, {7'h00, e});
    endtask
    task stop_test;
        $display("errors %0d, comparisons %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Watchdog far beyond the roughly two hundred cycles the run needs
    initial begin
        #50000;
        err_total++;
        stop_test;
    end
    initial begin
        rv = 16'($urandom(32'hd396));
        repeat (3) @(posedge sys_clk_i);
        resetn_i <= 1;
        @(posedge sys_clk_i);
        bus(0, 8'h0f, 8'h00);
        bus(0, 8'h20, 8'h00);
        bus(1, 8'h0f, 8'hff);
        bus(0, 8'h0f, 8'hbb);
        // One tick of each source; only the selected one counts
        for (int cs = 0; cs < 4; cs++) begin
            rv = 16'($urandom) | 16'h0100;
            bus(1, 8'h0f, 8'(cs));
            bus(1, 8'h10, rv[15:8]);
            bus(1, 8'h11, rv[7:0]);
            bus(1, 8'h0e, 8'h11);
            rn(1);
            for (int k = 0; k < 4; k++) pl(6'(1 << k));
            bus(1, 8'h10, ~rv[15:8]);
            bus(0, 8'h12, 8'((rv - 16'd1) >> 8));
            bus(0, 8'h13, 8'(rv - 16'd1));
            bus(1, 8'h0e, 8'hf0);
            rn(1);
            bus(1, 8'h0e, 8'h01);
        end
        bus(0, 8'h0e, 8'h00);
        bus(1, 8'h0f, 8'h08);
        bus(1, 8'h41, 8'h01);
        bus(1, 8'h10, 8'h00);
        bus(1, 8'h11, 8'h01);
        bus(1, 8'h0e, 8'h11);
        pl(6'h01);
        pl(6'h01);
        // The underflow count lands by non-blocking update, so let one edge settle it
        @(posedge sys_clk_i);
        chk(ufn, 8'h01);
        chk({7'h00, irq_o}, 8'h01);
        rn(1);
        bus(0, 8'h13, 8'h01);
        // Stops in the select loop left the stopped flag set beside the underflow flag
        bus(0, 8'h40, 8'h03);
        chk({7'h00, irq_o}, 8'h00);
        bus(1, 8'h0f, 8'h00);
        pl(6'h01);
        pl(6'h01);
        rn(0);
        pl(6'h10);
        rn(0);
        bus(1, 8'h0f, 8'h10);
        pl(6'h10);
        rn(1);
        // No counter reads while a frame arrives
        rx_active_i <= 1;
        repeat (4) pl(6'h20);
        rn(1);
        rx_active_i <= 0;
        bus(1, 8'h0f, 8'h90);
        rx_active_i <= 1;
        repeat (3) pl(6'h20);
        rn(1);
        pl(6'h20);
        rn(0);
        rx_active_i <= 0;
        bus(1, 8'h0f, 8'ha0);
        osc_trim_i <= 1;
        repeat (6) @(posedge sys_clk_i);
        rn(1);
        rx_active_i <= 1;
        repeat (4) pl(6'h20);
        rn(1);
        {rx_active_i, osc_trim_i} <= 2'b00;
        repeat (4) @(posedge sys_clk_i);
        osc_trim_i <= 1;
        repeat (6) @(posedge sys_clk_i);
        rn(0);
        stop_test;
    end
endmodule // testbench
